// file: hw/swc_map.svh
// Register addresses, field positions, reset values and timing constants
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH
`define SWC_ADDR_CAL_HIGH     7'h3A
`define SWC_ADDR_CAL_LOW      7'h3B
`define SWC_ADDR_CTRL_ONE     7'h3C
`define SWC_ADDR_CTRL_TWO     7'h3D
`define SWC_RST_CAL           8'h00
`define SWC_RST_CTRL_ONE      8'h04
`define SWC_RST_CTRL_TWO      8'h00
`define SWC_EN_BIT            0
`define SWC_FILT_LSB          2
`define SWC_FILT_MSB          3
`define SWC_CLK_LSB           0
`define SWC_CLK_MSB           1
`define SWC_FILT_TC8          2'h0
`define SWC_FILT_TC16         2'h1
`define SWC_FILT_TC32         2'h2
`define SWC_FILT_ADAPT        2'h3
`define SWC_SHIFT_TC8         5'h03
`define SWC_SHIFT_TC16        5'h04
`define SWC_SHIFT_TC32        5'h05
`define SWC_ADAPT_TC32_MAX    4'h3
`define SWC_ADAPT_TC16_MAX    4'h8
`define SWC_SPACING_MAX       4'hA
`define SWC_SPACING_OUT       4'hB
`define SWC_FRAC_BITS         8
`endif

// file: hw/swc_pkg.sv
// Types shared by the recovery control block
package swc_pkg;
  typedef enum logic [0:0] {
    SWC_IDLE  = 1'b0,
    SWC_TRACK = 1'b1
  } swc_mode_type;

  typedef struct packed {
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
    logic [6:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } swc_req_type;

  typedef struct packed {
    logic         rec_en;
    logic [1:0]   filt;
    logic [1:0]   clk_sel;
    swc_mode_type mode;
    logic         rx_prev;
    logic [11:0]  edge_cnt;
    logic [11:0]  phase;
    logic [15:0]  acc;
    logic [7:0]   cal_h;
    logic [7:0]   cal_l;
    logic [7:0]   rdata;
    logic         rec_data;
    logic         data_valid;
  } swc_state_type;
endpackage : swc_pkg

// file: hw/swc_tick_gen.sv
// Recovery clock enable divider, one pulse every 1, 2, 4 or 8 cycles
module swc_tick_gen (
  input  wire logic       clock,    // System clock
  input  wire logic       rstn,     // Async reset, active low
  input  wire logic [1:0] clk_sel,  // Recovery clock select
  output logic            tick      // One-cycle enable
);
  logic [2:0] cnt;
  logic [2:0] mask;

  // Base clock stands for the fastest recovery rate, code 00
  always_comb begin
    case (clk_sel)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    tick = (cnt & mask) == mask;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : swc_tick_gen

// file: hw/swc_recovery_ctrl.sv
// Selective-wake clock and data recovery control and tracking logic
// Functional notes
// - High calibration byte is read-only and resets to zero.
// - Low calibration byte is read-only and resets to zero.
// - Control one bits 3:2 pick filter constant 8, 16, 32 or adaptive.
// - Adaptive mode uses 32 for 2-3 bit spacing, 16 for 4-8, 8 for 9-10.
// - Reserved bits of both control registers read as zero.
// - Control one resets to 0x04: constant 16, recovery off.
// - Restart keeps filter and enable bits, reserved bits stay zero.
// - Control two bits 1:0 pick recovery clock 80, 40, 20 or 10 MHz.
// - Control two resets to zero and keeps its clock bits on restart.
// - Recovered bit time is clamped to the programmed limits; the start value from bit_time_setting is not.
`include "swc_map.svh"
module swc_recovery_ctrl (
  input  wire logic                 clock,                 // 80 MHz clock
  input  wire logic                 rstn,                  // Power-on reset
  input  wire logic                 soft_reset,            // Soft reset pulse
  input  wire logic                 restart,               // Restart pulse
  input  wire swc_pkg::swc_req_type reg_req,               // Register access
  output logic [7:0]                reg_rdata,             // Read data
  input  wire logic                 rx_in,                 // Bus receive level
  input  wire logic [7:0]           bit_time_setting,      // Nominal bit time
  input  wire logic [7:0]           bit_time_upper_limit,  // Upper clamp
  input  wire logic [7:0]           bit_time_lower_limit,  // Lower clamp
  output logic                      recovery_enable,       // Enable bit
  output logic [1:0]                filter_tc_select,      // Filter field
  output logic [1:0]                recovery_clock_select, // Clock field
  output logic                      recovery_active,       // Tracking
  output logic [7:0]                recovered_bit_time,    // Filtered bit
  output logic                      recovered_data,        // Sampled bit
  output logic                      data_valid             // Sample pulse
);
  localparam swc_pkg::swc_state_type RESET_STATE = '{
    rec_en:     1'b0,
    filt:       `SWC_FILT_TC16,
    clk_sel:    2'h0,
    mode:       swc_pkg::SWC_IDLE,
    rx_prev:    1'b1,
    edge_cnt:   12'h000,
    phase:      12'h000,
    acc:        16'h0000,
    cal_h:      `SWC_RST_CAL,
    cal_l:      `SWC_RST_CAL,
    rdata:      8'h00,
    rec_data:   1'b1,
    data_valid: 1'b0
  };

  swc_pkg::swc_state_type s;
  swc_pkg::swc_state_type next_s;
  logic               tick;
  logic               fall;
  logic [7:0]         bt;
  logic [3:0]         nb;
  logic [11:0]        span;
  logic [4:0]         sh;
  logic [19:0]        meas;
  logic signed [20:0] err;
  logic signed [20:0] upd;
  logic [15:0]        lim_lo;
  logic [15:0]        lim_hi;

  // Rounded number of bit times in a spacing; out of range reads as 11
  function automatic logic [3:0] bits_of(input logic [11:0] cnt,
                                         input logic [7:0]  bti);
    logic [15:0] thr;
    logic [3:0]  n;
    thr = 16'h0000;
    n   = `SWC_SPACING_OUT;
    for (int k = `SWC_SPACING_MAX; k >= 1; k--) begin
      thr = 16'(16'(2 * k - 1) * {8'h00, bti});
      if (bti != 8'h00 && {3'h0, cnt, 1'b0} >= thr) begin
        if (n == `SWC_SPACING_OUT) begin
          n = 4'(k);
        end
      end
    end
    if (bti != 8'h00 && {3'h0, cnt, 1'b0} >=
        16'(16'(2 * `SWC_SPACING_MAX + 1) * {8'h00, bti})) begin
      n = `SWC_SPACING_OUT;
    end
    return n;
  endfunction : bits_of

  // Per-bit time in 12.8 fixed point; constant divisors keep it cheap
  function automatic logic [19:0] per_bit(input logic [11:0] cnt,
                                          input logic [3:0]  n);
    logic [19:0] v;
    v = {cnt, 8'h00};
    case (n)
      4'h1:    per_bit = v;
      4'h2:    per_bit = v / 20'd2;
      4'h3:    per_bit = v / 20'd3;
      4'h4:    per_bit = v / 20'd4;
      4'h5:    per_bit = v / 20'd5;
      4'h6:    per_bit = v / 20'd6;
      4'h7:    per_bit = v / 20'd7;
      4'h8:    per_bit = v / 20'd8;
      4'h9:    per_bit = v / 20'd9;
      default: per_bit = v / 20'd10;
    endcase
  endfunction : per_bit

  // Filter shift; single-bit spacing is treated like the short case
  function automatic logic [4:0] tc_shift(input logic [1:0] f,
                                          input logic [3:0] n);
    case (f)
      `SWC_FILT_TC8:  tc_shift = `SWC_SHIFT_TC8;
      `SWC_FILT_TC16: tc_shift = `SWC_SHIFT_TC16;
      `SWC_FILT_TC32: tc_shift = `SWC_SHIFT_TC32;
      default: begin
        if (n <= `SWC_ADAPT_TC32_MAX) begin
          tc_shift = `SWC_SHIFT_TC32;
        end else if (n <= `SWC_ADAPT_TC16_MAX) begin
          tc_shift = `SWC_SHIFT_TC16;
        end else begin
          tc_shift = `SWC_SHIFT_TC8;
        end
      end
    endcase
  endfunction : tc_shift

  // Reserved bits are never stored, so they always read zero
  function automatic logic [7:0] read_mux(input swc_pkg::swc_state_type st,
                                          input logic [6:0] a);
    case (a)
      `SWC_ADDR_CAL_HIGH: read_mux = st.cal_h;
      `SWC_ADDR_CAL_LOW:  read_mux = st.cal_l;
      `SWC_ADDR_CTRL_ONE:
        read_mux = {4'h0, st.filt, 1'b0, st.rec_en};
      `SWC_ADDR_CTRL_TWO: read_mux = {6'h00, st.clk_sel};
      default:            read_mux = 8'h00;
    endcase
  endfunction : read_mux

  swc_tick_gen u_tick (
    .clock   (clock),
    .rstn    (rstn),
    .clk_sel (s.clk_sel),
    .tick    (tick)
  );

  always_comb begin
    fall   = s.rx_prev & ~rx_in;
    bt     = s.acc[15:8];
    // The tick of the edge that ends a spacing belongs to that spacing
    if (tick && s.edge_cnt != 12'hFFF) begin
      span = s.edge_cnt + 12'h001;
    end else begin
      span = s.edge_cnt;
    end
    nb     = bits_of(span, bt);
    sh     = tc_shift(s.filt, nb);
    meas   = per_bit(span, nb);
    err    = $signed({1'b0, meas}) - $signed({5'h00, s.acc});
    upd    = $signed({5'h00, s.acc}) + (err >>> sh);
    lim_lo = {bit_time_lower_limit, 8'h00};
    lim_hi = {bit_time_upper_limit, 8'hFF};
    next_s = s;
    next_s.data_valid = 1'b0;
    next_s.rx_prev    = rx_in;
    if (reg_req.rd) begin
      next_s.rdata = read_mux(s, reg_req.addr);
    end
    if (reg_req.wr) begin
      case (reg_req.addr)
        `SWC_ADDR_CTRL_ONE: begin
          next_s.rec_en = reg_req.wdata[`SWC_EN_BIT];
          next_s.filt = reg_req.wdata[`SWC_FILT_MSB:`SWC_FILT_LSB];
        end
        `SWC_ADDR_CTRL_TWO: begin
          next_s.clk_sel = reg_req.wdata[`SWC_CLK_MSB:`SWC_CLK_LSB];
        end
        default: begin
        end
      endcase
    end
    case (s.mode)
      swc_pkg::SWC_IDLE: begin
        if (s.rec_en) begin
          next_s.mode     = swc_pkg::SWC_TRACK;
          next_s.acc      = {bit_time_setting, 8'h00};
          next_s.edge_cnt = 12'h000;
          next_s.phase    = 12'h000;
        end
      end
      swc_pkg::SWC_TRACK: begin
        if (!s.rec_en) begin
          next_s.mode = swc_pkg::SWC_IDLE;
        end else if (fall) begin
          // Spacing outside 1..10 bits carries no usable timing
          if (nb != `SWC_SPACING_OUT) begin
            if (upd < $signed({5'h00, lim_lo})) begin
              next_s.acc = lim_lo;
            end else if (upd > $signed({5'h00, lim_hi})) begin
              next_s.acc = lim_hi;
            end else begin
              next_s.acc = upd[15:0];
            end
            next_s.cal_h = next_s.acc[15:8];
            next_s.cal_l = next_s.acc[7:0];
          end
          next_s.edge_cnt = 12'h000;
          next_s.phase    = 12'h000;
        end else if (tick) begin
          // Counter saturates rather than wrapping into a short spacing
          if (s.edge_cnt != 12'hFFF) begin
            next_s.edge_cnt = s.edge_cnt + 12'h001;
          end
          if (s.phase == {5'h00, bt[7:1]}) begin
            next_s.rec_data   = rx_in;
            next_s.data_valid = 1'b1;
          end
          if (s.phase + 12'h001 >= {4'h0, bt}) begin
            next_s.phase = 12'h000;
          end else begin
            next_s.phase = s.phase + 12'h001;
          end
        end
      end
      default: next_s.mode = swc_pkg::SWC_IDLE;
    endcase
    if (restart) begin
      // Control fields and calibration bytes hold their values
      next_s.mode       = swc_pkg::SWC_IDLE;
      next_s.data_valid = 1'b0;
    end
    if (soft_reset) begin
      next_s = RESET_STATE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    reg_rdata             = s.rdata;
    recovery_enable       = s.rec_en;
    filter_tc_select      = s.filt;
    recovery_clock_select = s.clk_sel;
    recovery_active       = s.mode == swc_pkg::SWC_TRACK;
    recovered_bit_time    = s.acc[15:8];
    recovered_data        = s.rec_data;
    data_valid            = s.data_valid;
  end
endmodule : swc_recovery_ctrl

// file: tb/swc_checker.sv
// Port assertions for the recovery control block
module swc_checker (
  input wire logic                 clock,                // Clk
  input wire logic                 rstn,                 // Rst
  input wire logic                 soft_reset,           // Soft
  input wire logic                 restart,              // Restart
  input wire swc_pkg::swc_req_type reg_req,              // Access
  input wire logic [7:0]           reg_rdata,            // Read
  input wire logic [7:0]           bit_time_upper_limit, // Upper
  input wire logic [7:0]           bit_time_lower_limit, // Lower
  input wire logic                 recovery_enable,      // Enable
  input wire logic [1:0]           filter_tc_select,     // Filter
  input wire logic [1:0]           recovery_clock_select, // Clk sel
  input wire logic                 recovery_active,      // Track
  input wire logic [7:0]           recovered_bit_time    // Bit time
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  wire logic [6:0] a = reg_req.addr;
  wire logic       w = reg_req.wr && !soft_reset;
  wire logic       r = reg_req.rd && !soft_reset;
  one_write_a:
    assert property (w && a == 7'h3C |=> filter_tc_select ==
      $past(reg_req.wdata[3:2]) && recovery_enable == $past(reg_req.wdata[0]))
    else $error("control one write lost");
  two_write_a:
    assert property (w && a == 7'h3D |=>
      recovery_clock_select == $past(reg_req.wdata[1:0]))
    else $error("control two write lost");
  one_read_a:
    assert property (r && a == 7'h3C |=> reg_rdata == {4'h0,
      $past(filter_tc_select), 1'b0, $past(recovery_enable)})
    else $error("control one read wrong");
  two_read_a:
    assert property (r && a == 7'h3D |=>
      reg_rdata == {6'h00, $past(recovery_clock_select)})
    else $error("control two read wrong");
  soft_clear_a:
    assert property (soft_reset |=> filter_tc_select == 2'h1 &&
      !recovery_enable && recovery_clock_select == 2'h0)
    else $error("soft reset values wrong");
  restart_hold_a:
    assert property (restart && !soft_reset && !reg_req.wr |=>
      $stable({filter_tc_select, recovery_enable, recovery_clock_select}))
    else $error("restart changed control");
  cal_zero_a:
    assert property (soft_reset ##[1:8] (r && a[6:1] == 6'h1D)
      |=> reg_rdata == 8'h00)
    else $error("calibration not zero");
  idle_off_a:
    assert property (!recovery_enable |=> !recovery_active)
    else $error("tracking while disabled");
  clamp_a:
    assert property (recovery_active && $past(recovery_active) |->
      recovered_bit_time <= bit_time_upper_limit &&
      recovered_bit_time >= bit_time_lower_limit)
    else $error("bit time outside limits");
  cover property (restart && recovery_enable);
  cover property (recovery_active);
  cover property (r && a == 7'h3C);
endmodule : swc_checker
bind swc_recovery_ctrl swc_checker chk (
  .clock                 (clock),
  .rstn                  (rstn),
  .soft_reset            (soft_reset),
  .restart               (restart),
  .reg_req               (reg_req),
  .reg_rdata             (reg_rdata),
  .bit_time_upper_limit  (bit_time_upper_limit),
  .bit_time_lower_limit  (bit_time_lower_limit),
  .recovery_enable       (recovery_enable),
  .filter_tc_select      (filter_tc_select),
  .recovery_clock_select (recovery_clock_select),
  .recovery_active       (recovery_active),
  .recovered_bit_time    (recovered_bit_time)
);

// file: tb/swc_host_model.sv
// Host side: bit-time settings and bus receive level
module swc_host_model (
  output logic       rx_in,                // Receive level
  output logic [7:0] bit_time_setting,     // Nominal
  output logic [7:0] bit_time_upper_limit, // Upper
  output logic [7:0] bit_time_lower_limit, // Lower
  input  wire logic  clock                 // Clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only the 80 MHz code at 500k; other rows lose precision or overflow
  initial begin
    rx_in = 1'b1;
    bit_time_setting = 8'hA0;
    bit_time_upper_limit = 8'hA8;
    bit_time_lower_limit = 8'h98;
  end
  task automatic set_upper(input logic [7:0] u);
    @(posedge clock);
    bit_time_upper_limit <= u;
  endtask : set_upper
  // First fall comes too soon to count, the second one is measured
  task automatic fall_pair(input int gap);
    @(posedge clock);
    rx_in <= 1'b0;
    repeat (100) @(posedge clock);
    rx_in <= 1'b1;
    repeat (gap - 100) @(posedge clock);
    rx_in <= 1'b0;
    repeat (100) @(posedge clock);
    rx_in <= 1'b1;
  endtask : fall_pair
endmodule : swc_host_model

// file: tb/tb_top.sv
// Register and recovery tests for the recovery control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 soft_reset = 1'b0;
  logic                 restart = 1'b0;
  swc_pkg::swc_req_type reg_req = '0;
  logic                 rx_in;
  logic [7:0]           reg_rdata;
  logic [7:0]           bit_time_setting;
  logic [7:0]           bit_time_upper_limit;
  logic [7:0]           bit_time_lower_limit;
  logic [7:0]           recovered_bit_time;
  logic                 recovery_enable;
  logic                 recovery_active;
  logic                 recovered_data;
  logic                 data_valid;
  logic [1:0]           filter_tc_select;
  logic [1:0]           recovery_clock_select;
  int                   failures = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  logic [7:0]           rst_val [4] = '{8'h00, 8'h00, 8'h04, 8'h00};
  logic [7:0]           rec_h [3] = '{8'hA1, 8'hA0, 8'hA0};
  logic [7:0]           rec_l [3] = '{8'h80, 8'hC0, 8'hFF};
  int                   valid_seen = 0;
  always #50 clock = ~clock;
  swc_host_model host (.rx_in, .bit_time_setting, .bit_time_upper_limit,
    .bit_time_lower_limit, .clock);
  swc_recovery_ctrl dut (.clock, .rstn, .soft_reset, .restart, .reg_req,
    .reg_rdata, .rx_in, .bit_time_setting, .bit_time_upper_limit,
    .bit_time_lower_limit, .recovery_enable, .filter_tc_select,
    .recovery_clock_select, .recovery_active, .recovered_bit_time,
    .recovered_data, .data_valid);
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic cmp(input string what, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    reg_req.wr <= 1'b0;
    #1;
  endtask : reg_write
  task automatic reg_read(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1 cmp($sformatf("reg %h", a), e, reg_rdata);
  endtask : reg_read
  // Hang guard, far above the roughly 1525 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (data_valid === 1'b1) valid_seen++;
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
      reg_read(7'h3A + 7'(i), rst_val[i]);
    reg_read(7'h10, 8'h00);
    reg_write(7'h3A, 8'h55);
    reg_write(7'h3B, 8'hAA);
    reg_read(7'h3A, 8'h00);
    reg_read(7'h3B, 8'h00);
    reg_write(7'h3C, 8'hFE);
    reg_read(7'h3C, 8'h0C);
    reg_write(7'h3D, 8'hFF);
    reg_read(7'h3D, 8'h03);
    for (int k = 0; k < 4; k++) begin
      reg_write(7'h3C, {4'h0, 2'(k), 2'h1});
      cmp("filter", 8'(k), {6'h00, filter_tc_select});
      cmp("enable", 8'h01, {7'h00, recovery_enable});
      reg_write(7'h3D, 8'(k));
      cmp("clock", 8'(k), {6'h00, recovery_clock_select});
    end
    reg_write(7'h3C, 8'h09);
    reg_write(7'h3D, 8'h02);
    @(posedge clock);
    restart <= 1'b1;
    @(posedge clock);
    restart <= 1'b0;
    reg_read(7'h3C, 8'h09);
    reg_read(7'h3D, 8'h02);
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    reg_read(7'h3A, 8'h00);
    reg_read(7'h3C, 8'h04);
    reg_read(7'h3D, 8'h00);
    // Spacing of 368 ticks rounds to two bits of 160 ticks each
    for (int t = 0; t < 3; t++) begin
      reg_write(7'h3C, 8'h00);
      host.set_upper(t == 2 ? 8'hA0 : 8'hA8);
      reg_write(7'h3C, t == 1 ? 8'h0D : 8'h05);
      valid_seen = 0;
      host.fall_pair(368);
      repeat (3) @(posedge clock);
      reg_read(7'h3A, rec_h[t]);
      cmp("bit time", rec_h[t], recovered_bit_time);
      reg_read(7'h3B, rec_l[t]);
      // Samples at half a bit: two in the first spacing, one after
      cmp("valid count", 8'h03, 8'(valid_seen));
      cmp("data", 8'h00, {7'h00, recovered_data});
    end
    reg_read(7'h3B, 8'hFF);
    final_report();
  end
endmodule : tb_top
